// *** design/ocs_pkg.sv ***
// Constants shared by the character-set, sync and fast-blanking block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package ocs_pkg;
    // ----------------------------------------------------------------
    // Clocking
    // ----------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 250;
    localparam int DOT_CLK_MHZ = 12;
    // Nearest whole divide keeps the dot rate closest to 12 MHz.
    localparam int DOT_DIV = (CORE_CLK_MHZ + DOT_CLK_MHZ / 2) / DOT_CLK_MHZ;
    localparam logic [4:0] DOT_LAST = 5'(DOT_DIV - 1);
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] CHARSET_OFS = 12'h000;
    localparam logic [11:0] ALTSET_OFS = 12'h004;
    localparam logic [11:0] REDEF_OFS = 12'h008;
    localparam logic [11:0] REGION_OFS = 12'h00C;
    localparam logic [11:0] SYNCPOL_OFS = 12'h010;
    localparam logic [11:0] SWITCH_OFS = 12'h014;
    localparam logic [11:0] STATUS_OFS = 12'h018;
    localparam logic [11:0] GLYPH_RAM_OFS = 12'h800;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BASIC_POS = 0;
    localparam int NATOPT_POS = 2;
    localparam int TWIST_POS = 0;
    localparam int ALT_ON_POS = 2;
    localparam int LANG_POS = 3;
    localparam int REMAP_POS = 0;
    localparam int PLANE_POS = 1;
    localparam int EASTWEST_POS = 0;
    localparam int HINV_POS = 0;
    localparam int VINV_POS = 1;
    localparam int SWPOL_POS = 0;
    localparam int SWDEL_POS = 1;
    localparam int CAPTION_POS = 4;
    // ----------------------------------------------------------------
    // Reset values, codes and glyph geometry
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] SWDEL_EARLY = 3'h1;
    localparam logic [2:0] SWDEL_LATE = 3'h2;
    localparam logic [4:0] NAT_NONE = 5'h1F;
    localparam logic [7:0] REDEF_FIRST = 8'h80;
    localparam logic [7:0] REDEF_LAST = 8'h9F;
    localparam int GLYPH_W = 12;
    localparam int GLYPH_ROWS = 16;
    localparam int REDEF_COUNT = 32;
    localparam logic [1:0] ROM_NAT = 2'h0;
    localparam logic [1:0] ROM_BASIC = 2'h1;
    localparam logic [1:0] ROM_PIXEL = 2'h2;

    typedef enum {S_IDLE, S_NAT, S_BASIC, S_PIX, S_OUT, S_REDEF} ocs_fetch_type;
endpackage : ocs_pkg

// *** design/ocs_charset_sync.sv ***
// Character-set selection, glyph fetch, sync conditioning and video switch.
// Assumes a combined glyph ROM with one cycle read latency on core_clk,
// sync pins asynchronous to core_clk, and display logic on core_clk.
// Notes on behaviour
// - Two-bit set code picks set 0 to set 3 directly.
// - Caption mode always uses the basic set only.
// - Teletext mode may show basic and twist sets together.
// - Twist set used only when enabled; three-bit language code accompanies it.
// - Four-bit national option plus east/west bit address up to 31 tables.
// - National, basic and pixel lookups share one ROM, accessed in turn.
// - Thirty-two redefinable glyphs at codes 80H-9FH, normal or special.
// - Remap enable substitutes redefinable data; plane bit picks special symbols.
// - Each normal redefinable glyph is one plane of 12 by 16 pixels; special symbols use two.
// - Each sync input has its own inversion bit.
// - Dot clock enable is derived at 12 MHz, locked to hsync.
// - Sync inputs are resynchronised to core_clk before use; display copies update on dot enables.
// - Switch high for RGB, low for video; polarity bit inverts both.
// - Switch sits one dot before, with, or one dot after RGB.
`timescale 1ns/1ps
module ocs_charset_sync #(
    parameter int ROM_DW = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    input wire logic char_valid,
    input wire logic [7:0] char_code,
    input wire logic char_alt,
    input wire logic [3:0] char_row,
    output logic char_ready,
    output logic [15:0] rom_addr,
    input wire logic [ROM_DW-1:0] rom_rdata,
    output logic [11:0] pix_bits,
    output logic [11:0] pix_plane1,
    output logic pix_valid,
    output logic [2:0] pix_language,
    output logic dot_en,
    output logic hsync_disp,
    output logic vsync_disp,
    input wire logic rgb_active,
    output logic rgb_enable,
    output logic video_rgb_switch
);
    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] charset_control_reg_r;
    logic [7:0] alt_charset_reg_r;
    logic [7:0] redefinable_control_reg_r;
    logic [7:0] region_control_reg_r;
    logic [7:0] sync_polarity_reg_r;
    logic [7:0] switch_control_reg_r;
    logic [11:0] redef_mem [0:ocs_pkg::REDEF_COUNT*ocs_pkg::GLYPH_ROWS-1];
    logic waitrequest_r;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic hs_disp_r;
    logic vs_disp_r;
    logic vds_r;
    ocs_pkg::ocs_fetch_type state_r;

    logic [1:0] basic_set_select;
    logic [3:0] natopt_select;
    logic [1:0] twist_set_select;
    logic alt_set_on;
    logic [2:0] alt_language_code;
    logic redefinable_remap_on;
    logic symbol_plane_choice;
    logic east_west;
    logic hsync_invert;
    logic vsync_invert;
    logic switch_polarity;
    logic [2:0] switch_delay;
    logic caption_mode;
    logic bus_fire;
    logic reg_wr;

    assign basic_set_select = charset_control_reg_r[ocs_pkg::BASIC_POS +: 2];
    assign natopt_select = charset_control_reg_r[ocs_pkg::NATOPT_POS +: 4];
    assign twist_set_select = alt_charset_reg_r[ocs_pkg::TWIST_POS +: 2];
    assign alt_set_on = alt_charset_reg_r[ocs_pkg::ALT_ON_POS];
    assign alt_language_code = alt_charset_reg_r[ocs_pkg::LANG_POS +: 3];
    assign redefinable_remap_on = redefinable_control_reg_r[ocs_pkg::REMAP_POS];
    assign symbol_plane_choice = redefinable_control_reg_r[ocs_pkg::PLANE_POS];
    assign east_west = region_control_reg_r[ocs_pkg::EASTWEST_POS];
    assign hsync_invert = sync_polarity_reg_r[ocs_pkg::HINV_POS];
    assign vsync_invert = sync_polarity_reg_r[ocs_pkg::VINV_POS];
    assign switch_polarity = switch_control_reg_r[ocs_pkg::SWPOL_POS];
    assign switch_delay = switch_control_reg_r[ocs_pkg::SWDEL_POS +: 3];
    assign caption_mode = switch_control_reg_r[ocs_pkg::CAPTION_POS];

    // The request is answered one cycle after it is first seen.
    assign bus_fire = (avs_read || avs_write) && !waitrequest_r;
    assign reg_wr = bus_fire && avs_write && avs_byteenable[0];

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            waitrequest_r <= 1'b1;
        else if (bus_fire)
            waitrequest_r <= 1'b1;
        else if (avs_read || avs_write)
            waitrequest_r <= 1'b0;
    end

    always_comb
    begin
        readdata_nxt = 32'h0000_0000;
        case ({avs_address[11:2], 2'b00})
            ocs_pkg::CHARSET_OFS: readdata_nxt[7:0] = charset_control_reg_r;
            ocs_pkg::ALTSET_OFS: readdata_nxt[7:0] = alt_charset_reg_r;
            ocs_pkg::REDEF_OFS: readdata_nxt[7:0] = redefinable_control_reg_r;
            ocs_pkg::REGION_OFS: readdata_nxt[7:0] = region_control_reg_r;
            ocs_pkg::SYNCPOL_OFS: readdata_nxt[7:0] = sync_polarity_reg_r;
            ocs_pkg::SWITCH_OFS: readdata_nxt[7:0] = switch_control_reg_r;
            ocs_pkg::STATUS_OFS:
                readdata_nxt[3:0] = {state_r != ocs_pkg::S_IDLE, vds_r, vs_disp_r, hs_disp_r};
            default: readdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            readdata_r <= 32'h0000_0000;
        else if (avs_read && waitrequest_r)
            readdata_r <= readdata_nxt;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            charset_control_reg_r <= ocs_pkg::REG_RESET;
            alt_charset_reg_r <= ocs_pkg::REG_RESET;
            redefinable_control_reg_r <= ocs_pkg::REG_RESET;
            region_control_reg_r <= ocs_pkg::REG_RESET;
            sync_polarity_reg_r <= ocs_pkg::REG_RESET;
            switch_control_reg_r <= ocs_pkg::REG_RESET;
        end
        else if (reg_wr)
        begin
            case ({avs_address[11:2], 2'b00})
                ocs_pkg::CHARSET_OFS: charset_control_reg_r <= avs_writedata[7:0];
                ocs_pkg::ALTSET_OFS: alt_charset_reg_r <= avs_writedata[7:0];
                ocs_pkg::REDEF_OFS: redefinable_control_reg_r <= avs_writedata[7:0];
                ocs_pkg::REGION_OFS: region_control_reg_r <= avs_writedata[7:0];
                ocs_pkg::SYNCPOL_OFS: sync_polarity_reg_r <= avs_writedata[7:0];
                ocs_pkg::SWITCH_OFS: switch_control_reg_r <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // Glyph rows are written one 12-bit word per bus word; the array has
    // no reset, so software must load a glyph before enabling the remap.
    always_ff @(posedge core_clk)
    begin
        if (bus_fire && avs_write && avs_address[11] && (&avs_byteenable[1:0]))
            redef_mem[avs_address[10:2]] <= avs_writedata[11:0];
    end

    // ----------------------------------------------------------------
    // Sync conditioning and dot clock enable
    // ----------------------------------------------------------------
    logic [1:0] hs_sync_r;
    logic [1:0] vs_sync_r;
    logic hs_prev_r;
    logic [4:0] dot_cnt_r;
    logic dot_en_r;
    logic hs_int;
    logic vs_int;
    logic hs_edge;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            hs_sync_r <= 2'b00;
            vs_sync_r <= 2'b00;
        end
        else
        begin
            hs_sync_r <= {hs_sync_r[0], hsync_pin};
            vs_sync_r <= {vs_sync_r[0], vsync_pin};
        end
    end

    assign hs_int = hs_sync_r[1] ^ hsync_invert;
    assign vs_int = vs_sync_r[1] ^ vsync_invert;
    assign hs_edge = hs_int && !hs_prev_r;

    // Restarting the divider on each hsync leading edge locks the dot
    // phase to the line, at the cost of one short dot at that edge.
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            hs_prev_r <= 1'b0;
            dot_cnt_r <= 5'h00;
            dot_en_r <= 1'b0;
        end
        else
        begin
            hs_prev_r <= hs_int;
            if (hs_edge || dot_cnt_r == ocs_pkg::DOT_LAST)
            begin
                dot_cnt_r <= 5'h00;
                dot_en_r <= 1'b1;
            end
            else
            begin
                dot_cnt_r <= dot_cnt_r + 5'h01;
                dot_en_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            hs_disp_r <= 1'b0;
            vs_disp_r <= 1'b0;
        end
        else if (dot_en_r)
        begin
            hs_disp_r <= hs_int;
            vs_disp_r <= vs_int;
        end
    end

    // ----------------------------------------------------------------
    // Video/data switch alignment
    // ----------------------------------------------------------------
    logic [2:0] act_r;
    logic rgb_en_r;
    logic vds_sel;

    always_comb
    begin
        case (switch_delay)
            ocs_pkg::SWDEL_EARLY: vds_sel = act_r[0];
            ocs_pkg::SWDEL_LATE: vds_sel = act_r[2];
            default: vds_sel = act_r[1];
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            act_r <= 3'h0;
            rgb_en_r <= 1'b0;
            vds_r <= 1'b0;
        end
        else if (dot_en_r)
        begin
            act_r <= {act_r[1:0], rgb_active};
            rgb_en_r <= act_r[1];
            vds_r <= vds_sel ^ switch_polarity;
        end
    end

    // ----------------------------------------------------------------
    // Character fetch through the shared ROM
    // ----------------------------------------------------------------
    logic [7:0] code_r;
    logic [3:0] row_r;
    logic [1:0] cur_set_r;
    logic [2:0] lang_r;
    logic [15:0] rom_addr_r;
    logic [11:0] pix_r;
    logic [11:0] pix1_r;
    logic pix_valid_r;
    logic ready_r;
    logic rom_wait_r;
    logic [4:0] nat_idx;
    logic redef_hit;
    logic [4:0] redef_idx;

    // Index 31 is not a table; it falls back to table 0.
    assign nat_idx = ({east_west, natopt_select} == ocs_pkg::NAT_NONE) ?
                     5'h00 : {east_west, natopt_select};
    assign redef_hit = redefinable_remap_on && char_code >= ocs_pkg::REDEF_FIRST
                       && char_code <= ocs_pkg::REDEF_LAST;
    // Special symbols pair location n with n+16 as their two planes.
    assign redef_idx = symbol_plane_choice ? {1'b0, code_r[3:0]} : code_r[4:0];

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state_r <= ocs_pkg::S_IDLE;
            code_r <= 8'h00;
            row_r <= 4'h0;
            cur_set_r <= 2'h0;
            lang_r <= 3'h0;
            rom_addr_r <= 16'h0000;
            pix_r <= 12'h000;
            pix1_r <= 12'h000;
            pix_valid_r <= 1'b0;
            ready_r <= 1'b0;
            rom_wait_r <= 1'b0;
        end
        else
        begin
            pix_valid_r <= 1'b0;
            case (state_r)
                ocs_pkg::S_IDLE:
                begin
                    ready_r <= 1'b1;
                    if (char_valid && ready_r)
                    begin
                        ready_r <= 1'b0;
                        code_r <= char_code;
                        row_r <= char_row;
                        lang_r <= 3'h0;
                        cur_set_r <= basic_set_select;
                        if (!caption_mode && char_alt && alt_set_on)
                        begin
                            cur_set_r <= twist_set_select;
                            lang_r <= alt_language_code;
                        end
                        if (redef_hit)
                            state_r <= ocs_pkg::S_REDEF;
                        else
                        begin
                            rom_addr_r <= {ocs_pkg::ROM_NAT, 6'h00, nat_idx,
                                           (!caption_mode && char_alt && alt_set_on) ?
                                           alt_language_code : 3'h0};
                            state_r <= ocs_pkg::S_NAT;
                        end
                    end
                end
                ocs_pkg::S_NAT:
                begin
                    // The ROM answers one cycle after it samples the address, so each
                    // lookup spends a second cycle here before its data is used.
                    rom_wait_r <= !rom_wait_r;
                    if (rom_wait_r)
                    begin
                        // A non-zero national entry replaces the character code.
                        rom_addr_r <= {ocs_pkg::ROM_BASIC, 4'h0, cur_set_r,
                                       (rom_rdata[7:0] != 8'h00) ? rom_rdata[7:0] : code_r};
                        state_r <= ocs_pkg::S_BASIC;
                    end
                end
                ocs_pkg::S_BASIC:
                begin
                    rom_wait_r <= !rom_wait_r;
                    if (rom_wait_r)
                    begin
                        rom_addr_r <= {ocs_pkg::ROM_PIXEL, rom_rdata[9:0], row_r};
                        state_r <= ocs_pkg::S_PIX;
                    end
                end
                ocs_pkg::S_PIX:
                    state_r <= ocs_pkg::S_OUT;
                ocs_pkg::S_OUT:
                begin
                    pix_r <= rom_rdata[11:0];
                    pix1_r <= 12'h000;
                    pix_valid_r <= 1'b1;
                    state_r <= ocs_pkg::S_IDLE;
                end
                ocs_pkg::S_REDEF:
                begin
                    pix_r <= redef_mem[{redef_idx, row_r}];
                    pix1_r <= symbol_plane_choice ?
                              redef_mem[{redef_idx | 5'h10, row_r}] : 12'h000;
                    pix_valid_r <= 1'b1;
                    state_r <= ocs_pkg::S_IDLE;
                end
                default: state_r <= ocs_pkg::S_IDLE;
            endcase
        end
    end

    assign avs_readdata = readdata_r;
    assign avs_waitrequest = waitrequest_r;
    assign char_ready = ready_r;
    assign rom_addr = rom_addr_r;
    assign pix_bits = pix_r;
    assign pix_plane1 = pix1_r;
    assign pix_valid = pix_valid_r;
    assign pix_language = lang_r;
    assign dot_en = dot_en_r;
    assign hsync_disp = hs_disp_r;
    assign vsync_disp = vs_disp_r;
    assign rgb_enable = rgb_en_r;
    assign video_rgb_switch = vds_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic take;
    assign take = state_r == ocs_pkg::S_IDLE && char_valid && ready_r;

    property p_caption_basic;
        take && caption_mode |=> cur_set_r == $past(basic_set_select);
    endproperty
    a_caption_basic: assert property (p_caption_basic) else $error("caption set wrong");

    property p_twist_used;
        take && !caption_mode && char_alt && alt_set_on && !redef_hit
            |=> cur_set_r == $past(twist_set_select) ##6 pix_valid_r;
    endproperty
    a_twist_used: assert property (p_twist_used) else $error("twist set wrong");

    property p_alt_off;
        take && !alt_set_on |=> cur_set_r == $past(basic_set_select) && lang_r == 3'h0;
    endproperty
    a_alt_off: assert property (p_alt_off) else $error("alt set used while off");

    property p_redef;
        take && redef_hit |=> state_r == ocs_pkg::S_REDEF ##1 pix_valid_r;
    endproperty
    a_redef: assert property (p_redef) else $error("redefinable path missed");

    property p_rom_order;
        state_r == ocs_pkg::S_NAT && rom_wait_r
            |=> rom_addr_r[15:14] == ocs_pkg::ROM_BASIC
            ##2 rom_addr_r[15:14] == ocs_pkg::ROM_PIXEL;
    endproperty
    a_rom_order: assert property (p_rom_order) else $error("ROM order wrong");

    property p_line_lock;
        hs_edge |=> dot_en_r ##1 !dot_en_r [*8];
    endproperty
    a_line_lock: assert property (p_line_lock) else $error("dot not locked");

    property p_resync;
        !dot_en_r |=> $stable(hs_disp_r) && $stable(vs_disp_r);
    endproperty
    a_resync: assert property (p_resync) else $error("sync moved off dot");

    property p_switch_pol;
        dot_en_r && switch_delay != ocs_pkg::SWDEL_EARLY && switch_delay != ocs_pkg::SWDEL_LATE
            && act_r[1] |=> vds_r == !$past(switch_polarity);
    endproperty
    a_switch_pol: assert property (p_switch_pol) else $error("switch level wrong");

    property p_bus_answer;
        (avs_read || avs_write) && waitrequest_r |=> !waitrequest_r ##1 waitrequest_r;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_redef: cover property (take && redef_hit && symbol_plane_choice);
    c_twist: cover property (take && char_alt && alt_set_on && !caption_mode);
    c_early: cover property (dot_en_r && switch_delay == ocs_pkg::SWDEL_EARLY && vds_r);
endmodule : ocs_charset_sync

// *** test/ocs_tv_side.sv ***
// TV deflection model: drives both sync pins from levels set by the bench.
// Assumes the levels change just after rising edges of core_clk.
`timescale 1ns/1ps
module ocs_tv_side (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hs_level,
    input wire logic vs_level,
    output logic hsync_pin,
    output logic vsync_pin
);
    // The pins idle high in reset, as a deflection stage with pull-ups would.
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            hsync_pin <= 1'b1;
            vsync_pin <= 1'b1;
        end
        else
        begin
            hsync_pin <= hs_level;
            vsync_pin <= vs_level;
        end
    end
endmodule : ocs_tv_side

// *** test/tb.sv ***
// Self-checking bench for the character-set, sync and switch block.
// Assumes the designer's bus and fetch timing; ROM and TV side are models.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, char_ready, pix_valid, dot_en, hsync_disp, vsync_disp;
    logic char_valid = 1'b0;
    logic [7:0] char_code = 8'h00;
    logic char_alt = 1'b0;
    logic [15:0] rom_addr;
    logic [15:0] rom_rdata;
    logic [11:0] pix_bits, pix_plane1;
    logic [2:0] pix_language;
    logic rgb_active = 1'b0;
    logic rgb_enable, video_rgb_switch, hsync_pin, vsync_pin;
    logic hs_level = 1'b1;
    logic vs_level = 1'b1;
    logic [31:0] rd;
    logic [11:0] bits, bits1;
    logic [2:0] lang;
    int error_cnt = 0;
    int checked = 0;
    int n, t1, t2;
    logic [4:0] sw_code [5] = '{5'h00, 5'h02, 5'h04, 5'h0A, 5'h01};
    int sw_off [5] = '{0, -ocs_pkg::DOT_DIV, ocs_pkg::DOT_DIV, 0, 0};

    always #2 core_clk = ~core_clk;

    // Stand-in ROM with one cycle of read latency.
    always_ff @(posedge core_clk)
    begin
        rom_rdata <= rom_addr ^ 16'h5A5A;
    end

    ocs_charset_sync i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hsync_pin(hsync_pin), .vsync_pin(vsync_pin),
        .char_valid(char_valid), .char_code(char_code), .char_alt(char_alt),
        .char_row(4'h3), .char_ready(char_ready), .rom_addr(rom_addr),
        .rom_rdata(rom_rdata), .pix_bits(pix_bits), .pix_plane1(pix_plane1),
        .pix_valid(pix_valid),
        .pix_language(pix_language), .dot_en(dot_en), .hsync_disp(hsync_disp),
        .vsync_disp(vsync_disp), .rgb_active(rgb_active), .rgb_enable(rgb_enable),
        .video_rgb_switch(video_rgb_switch));

    ocs_tv_side i_tv (.core_clk(core_clk), .reset_n(reset_n), .hs_level(hs_level),
        .vs_level(vs_level), .hsync_pin(hsync_pin), .vsync_pin(vsync_pin));

    task automatic finish_test();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // A bounded wait on a level seen at falling edges; running out ends the run.
    task automatic wait_lvl(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 300)
        begin
            error_cnt++;
            finish_test();
        end
    endtask : wait_lvl

    task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        w = 0;
        do
        begin
            @(posedge core_clk);
            w++;
        end
        while (avs_waitrequest !== 1'b0 && w < 300);
        // Waitrequest and read data are the values the slave shows at this edge.
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            error_cnt++;
            finish_test();
        end
    endtask : bus_xfer

    task automatic fetch(input logic [7:0] c, input logic alt);
        @(posedge core_clk);
        char_valid <= 1'b1;
        char_code <= c;
        char_alt <= alt;
        wait_lvl(char_ready, 1'b1);
        @(posedge core_clk);
        char_valid <= 1'b0;
        wait_lvl(pix_valid, 1'b1);
        bits = pix_bits;
        lang = pix_language;
        bits1 = pix_plane1;
    endtask : fetch

    initial
    begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        bus_xfer(1'b0, ocs_pkg::CHARSET_OFS, 32'h0);
        `CHK(rd, 32'h0)
        bus_xfer(1'b0, 12'h01C, 32'h0);
        `CHK(rd, 32'h0)
        for (int s = 0; s < 4; s++)
        begin
            bus_xfer(1'b1, ocs_pkg::CHARSET_OFS, 32'(s + 8'h28));
            bus_xfer(1'b0, ocs_pkg::CHARSET_OFS, 32'h0);
            `CHK(rd, 32'(s + 8'h28))
        end
        bus_xfer(1'b1, ocs_pkg::ALTSET_OFS, 32'h2E);
        fetch(8'h41, 1'b1);
        `CHK(lang, 3'h5)
        `CHK(bits, 12'hF09)
        bus_xfer(1'b1, ocs_pkg::ALTSET_OFS, 32'h2A);
        fetch(8'h41, 1'b1);
        `CHK(lang, 3'h0)
        bus_xfer(1'b1, ocs_pkg::ALTSET_OFS, 32'h2F);
        bus_xfer(1'b1, ocs_pkg::SWITCH_OFS, 32'h10);
        fetch(8'h41, 1'b1);
        `CHK(lang, 3'h0)
        bus_xfer(1'b1, 12'h94C, 32'h0ABC);
        bus_xfer(1'b1, 12'hFCC, 32'h05A3);
        bus_xfer(1'b1, 12'hD4C, 32'h03C5);
        bus_xfer(1'b1, ocs_pkg::REDEF_OFS, 32'h1);
        fetch(8'h85, 1'b0);
        `CHK(bits, 12'hABC)
        fetch(8'h9F, 1'b0);
        `CHK(bits, 12'h5A3)
        `CHK(bits1, 12'h000)
        bus_xfer(1'b1, ocs_pkg::REDEF_OFS, 32'h3);
        fetch(8'h95, 1'b0);
        `CHK(bits, 12'hABC)
        `CHK(bits1, 12'h3C5)
        bus_xfer(1'b1, ocs_pkg::SYNCPOL_OFS, 32'h3);
        wait_lvl(hsync_disp, 1'b0);
        `CHK(n < 30, 1'b1)
        `CHK(vsync_disp, 1'b0)
        @(posedge core_clk);
        hs_level <= 1'b0;
        vs_level <= 1'b0;
        wait_lvl(hsync_disp, 1'b1);
        `CHK(n < 8, 1'b1)
        `CHK(vsync_disp, 1'b1)
        bus_xfer(1'b0, ocs_pkg::STATUS_OFS, 32'h0);
        `CHK(rd[1:0], 2'h3)
        wait_lvl(dot_en, 1'b1);
        @(negedge core_clk);
        wait_lvl(dot_en, 1'b1);
        `CHK(n + 1, ocs_pkg::DOT_DIV)
        for (int k = 0; k < 5; k++)
        begin
            bus_xfer(1'b1, ocs_pkg::SWITCH_OFS, 32'(sw_code[k]));
            repeat (100) @(posedge core_clk);
            `CHK(video_rgb_switch, sw_code[k][0])
            rgb_active <= 1'b1;
            t1 = 0;
            t2 = 0;
            for (int c = 1; c < 300 && (t1 == 0 || t2 == 0); c++)
            begin
                @(negedge core_clk);
                if (t1 == 0 && rgb_enable === 1'b1) t1 = c;
                if (t2 == 0 && video_rgb_switch === !sw_code[k][0]) t2 = c;
            end
            `CHK(t2 - t1, sw_off[k])
            @(posedge core_clk);
            rgb_active <= 1'b0;
        end
        finish_test();
    end
endmodule : tb
